// [cevs_regs.sv]
// CAN event/status registers behind an AHB-Lite slave.
// Assumes event pulses and state levels come from controller logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Matched filter index reads 0 to 15; codes above are never produced.
// - Source code: 40 none, 41 error, 42 wake, 43 overflow, 44 FIFO.
// - Buffer events report their buffer number, 0 to 15.
// - Reserved source codes are never produced.
// - Region size codes 0 to 6 select 4 to 32 buffers; 7 reserved.
// - Writable five-bit FIFO start buffer.
// - Read-only FIFO write pointer, 0 to 31.
// - Read-only FIFO next-read pointer, 0 to 31.
// - Bus-off bit follows transmitter bus-off state.
// - Separate tx and rx error-passive bits follow their states.
// - Separate tx and rx warning bits follow their states.
// - Combined warning bit is tx warning or rx warning.
// - Error flag is raised by any error-state source entry.
// - Events set flags; software clears by writing 0, writing 1 keeps.
// - Flags at bits 7,6,5,3,2,1,0 as listed.
// - Enable register mirrors flag positions; 1 enables the request.
// - Unimplemented bits read 0 and ignore writes.
// - Wake flag still sets while the module is disabled.
module cevs_regs (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Controller events, one-cycle pulses; moduleDisabled is a level
	input wire logic evTxBuf,
	input wire logic evRxBuf,
	input wire logic [3:0] evBufNum,
	input wire logic [3:0] evFilterHit,
	input wire logic evOverflow,
	input wire logic evFifoAlmostFull,
	input wire logic evInvalid,
	input wire logic busActivity,
	input wire logic moduleDisabled,
	// Error-state levels
	input wire logic txBusOff,
	input wire logic txPassive,
	input wire logic rxPassive,
	input wire logic txWarning,
	input wire logic rxWarning,
	// FIFO pointer updates
	input wire logic fifoWriteAdvance,
	input wire logic fifoReadAdvance,
	// Outputs to the controller
	output logic [2:0] bufferRegionSize,
	output logic [4:0] fifoStartBuffer,
	output logic irqRequest
);

	// ****************************************
	// Bus decode
	// ****************************************
	logic dataPhase_q;
	logic dataWrite_q;
	logic [7:0] dataAddr_q;
	logic [7:0] flags_q;
	logic [7:0] enables_q;
	logic [2:0] regionSize_q;
	logic [4:0] fifoStart_q;
	logic [5:0] wrPtr_q;
	logic [5:0] rdPtr_q;
	logic [3:0] filterHit_q;
	logic [6:0] srcCode_q;
	logic [4:0] errState_q;
	logic [7:0] flagSet;
	logic [4:0] errStateNow;
	logic [6:0] srcCode_d;
	logic [3:0] bufNum_q;
	logic wrFlg;
	logic wrCfg;
	logic wrEna;
	logic addrTake;
	logic [7:0] flags_d;
	logic [7:0] enables_d;
	logic [2:0] regionSize_d;
	logic [4:0] fifoStart_d;
	logic [5:0] wrPtr_d;
	logic [5:0] rdPtr_d;
	logic [31:0] readWord_d;

	// Address phase accepted at this edge; with one slave hready is our own ready
	assign addrTake = hready && hsel && htrans[1];

	// Capture the address phase; every access completes in one data cycle
	always_ff @(posedge clock) begin
		if (!nrst) begin
			dataPhase_q <= 1'b0;
			dataWrite_q <= 1'b0;
			dataAddr_q <= 8'h00;
		end else if (hready) begin
			dataPhase_q <= hsel && htrans[1];
			dataWrite_q <= hwrite;
			dataAddr_q <= haddr[7:0];
		end
	end

	// Write strobe for one register, high through the data phase of a write to it
	// All arguments are passed in so the strobes re-evaluate on every operand
	function automatic logic wrDecode(input logic phase, input logic isWr,
		input logic [7:0] a, input logic [7:0] off);
		wrDecode = phase && isWr && (a == off);
	endfunction

	// Per-register write strobes
	assign wrFlg = wrDecode(dataPhase_q, dataWrite_q, dataAddr_q, cevs_pkg::OFF_FLG);
	assign wrCfg = wrDecode(dataPhase_q, dataWrite_q, dataAddr_q, cevs_pkg::OFF_CFG);
	assign wrEna = wrDecode(dataPhase_q, dataWrite_q, dataAddr_q, cevs_pkg::OFF_ENA);

	// Zero-wait slave, always OKAY
	always_ff @(posedge clock) begin
		if (!nrst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ****************************************
	// Error state and event flags
	// ****************************************
	assign errStateNow = {txBusOff, txPassive, rxPassive, txWarning, rxWarning};

	// Error state levels held one cycle; rising edges raise the error flag
	always_ff @(posedge clock) begin
		if (!nrst) begin
			errState_q <= 5'h00;
		end else begin
			errState_q <= errStateNow;
		end
	end

	// Set sources per flag position
	always_comb begin
		flagSet = 8'h00;
		flagSet[cevs_pkg::BIT_TXBUF] = evTxBuf;
		flagSet[cevs_pkg::BIT_RXBUF] = evRxBuf;
		flagSet[cevs_pkg::BIT_OVF] = evOverflow;
		flagSet[cevs_pkg::BIT_FIFO] = evFifoAlmostFull;
		flagSet[cevs_pkg::BIT_ERR] = |(errStateNow & ~errState_q);
		flagSet[cevs_pkg::BIT_WAKE] = busActivity && moduleDisabled;
		flagSet[cevs_pkg::BIT_INVALID] = evInvalid;
	end

	// Next flags: writing 0 clears, writing 1 keeps; a set in the same cycle wins
	// so an event that lands during a clear is never lost
	always_comb begin
		flags_d = flags_q | flagSet;
		if (wrFlg) begin
			flags_d = (flags_q & hwdata[7:0]) | flagSet;
		end
		flags_d = flags_d & cevs_pkg::FLAG_MASK;
	end

	// Flag register
	always_ff @(posedge clock) begin
		if (!nrst) begin
			flags_q <= cevs_pkg::RST_FLAGS;
		end else begin
			flags_q <= flags_d;
		end
	end

	// Next enables, bit 4 unimplemented
	always_comb begin
		enables_d = enables_q;
		if (wrEna) begin
			enables_d = hwdata[7:0] & cevs_pkg::FLAG_MASK;
		end
	end

	// Enable register
	always_ff @(posedge clock) begin
		if (!nrst) begin
			enables_q <= cevs_pkg::RST_FLAGS;
		end else begin
			enables_q <= enables_d;
		end
	end

	// Interrupt request from any enabled flag
	always_ff @(posedge clock) begin
		if (!nrst) begin
			irqRequest <= 1'b0;
		end else begin
			irqRequest <= |(flags_q & enables_q);
		end
	end

	// ****************************************
	// Configuration and FIFO pointers
	// ****************************************
	// Reserved size code is refused so the region stays valid; start is still taken
	always_comb begin
		regionSize_d = regionSize_q;
		fifoStart_d = fifoStart_q;
		if (wrCfg) begin
			if (hwdata[cevs_pkg::POS_SIZE +: 3] != cevs_pkg::SIZE_RESERVED) begin
				regionSize_d = hwdata[cevs_pkg::POS_SIZE +: 3];
			end
			fifoStart_d = hwdata[4:0];
		end
	end

	// Configuration register
	always_ff @(posedge clock) begin
		if (!nrst) begin
			regionSize_q <= cevs_pkg::RST_SIZE;
			fifoStart_q <= cevs_pkg::RST_START;
		end else begin
			regionSize_q <= regionSize_d;
			fifoStart_q <= fifoStart_d;
		end
	end

	assign bufferRegionSize = regionSize_q;
	assign fifoStartBuffer = fifoStart_q;

	// Pointers wrap from the last buffer back to the FIFO start
	function automatic logic [5:0] nextPtr(input logic [5:0] p, input logic [4:0] start);
		nextPtr = (p >= cevs_pkg::PTR_MAX) ? {1'b0, start} : p + 6'h01;
	endfunction

	// Next pointers; a config write reloads both, so a step in that cycle is dropped
	always_comb begin
		wrPtr_d = wrPtr_q;
		rdPtr_d = rdPtr_q;
		if (wrCfg) begin
			wrPtr_d = {1'b0, hwdata[4:0]};
			rdPtr_d = {1'b0, hwdata[4:0]};
		end else begin
			if (fifoWriteAdvance) begin
				wrPtr_d = nextPtr(wrPtr_q, fifoStart_q);
			end
			if (fifoReadAdvance) begin
				rdPtr_d = nextPtr(rdPtr_q, fifoStart_q);
			end
		end
	end

	// FIFO write pointer
	always_ff @(posedge clock) begin
		if (!nrst) begin
			wrPtr_q <= cevs_pkg::RST_PTR;
		end else begin
			wrPtr_q <= wrPtr_d;
		end
	end

	// FIFO next-read pointer
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rdPtr_q <= cevs_pkg::RST_PTR;
		end else begin
			rdPtr_q <= rdPtr_d;
		end
	end

	// ****************************************
	// Vector code
	// ****************************************
	// Filter hit and buffer number of the latest buffer event
	always_ff @(posedge clock) begin
		if (!nrst) begin
			filterHit_q <= cevs_pkg::RST_HIT;
			bufNum_q <= cevs_pkg::RST_HIT;
		end else if (evTxBuf || evRxBuf) begin
			filterHit_q <= evFilterHit;
			bufNum_q <= evBufNum;
		end
	end

	// Fixed priority: error, wake, overflow, FIFO, then buffers; invalid has no code
	always_comb begin
		srcCode_d = cevs_pkg::CODE_NONE;
		if (flags_q[cevs_pkg::BIT_ERR] && enables_q[cevs_pkg::BIT_ERR]) begin
			srcCode_d = cevs_pkg::CODE_ERR;
		end else if (flags_q[cevs_pkg::BIT_WAKE] && enables_q[cevs_pkg::BIT_WAKE]) begin
			srcCode_d = cevs_pkg::CODE_WAKE;
		end else if (flags_q[cevs_pkg::BIT_OVF] && enables_q[cevs_pkg::BIT_OVF]) begin
			srcCode_d = cevs_pkg::CODE_OVF;
		end else if (flags_q[cevs_pkg::BIT_FIFO] && enables_q[cevs_pkg::BIT_FIFO]) begin
			srcCode_d = cevs_pkg::CODE_FIFO;
		end else if ((flags_q[cevs_pkg::BIT_RXBUF] && enables_q[cevs_pkg::BIT_RXBUF]) ||
			(flags_q[cevs_pkg::BIT_TXBUF] && enables_q[cevs_pkg::BIT_TXBUF])) begin
			srcCode_d = {3'h0, bufNum_q};
		end
	end

	always_ff @(posedge clock) begin
		if (!nrst) begin
			srcCode_q <= cevs_pkg::CODE_NONE;
		end else begin
			srcCode_q <= srcCode_d;
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	// Config, pointer, flag and enable fields use next values: a read whose address phase meets the
	// data phase of a write to the same register returns what that write stores,
	// so back-to-back transfers need no wait state
	always_comb begin
		unique case (haddr[7:0])
			cevs_pkg::OFF_VEC:
				readWord_d = {19'h00000, 1'b0, filterHit_q, 1'b0, srcCode_q};
			cevs_pkg::OFF_CFG:
				readWord_d = {16'h0000, regionSize_d, 8'h00, fifoStart_d};
			cevs_pkg::OFF_PTR:
				readWord_d = {18'h00000, wrPtr_d, 2'h0, rdPtr_d};
			cevs_pkg::OFF_FLG:
				readWord_d = {18'h00000, errState_q[4:3], errState_q[2:0] & 3'h7,
					|errState_q[1:0], flags_d};
			cevs_pkg::OFF_ENA:
				readWord_d = {24'h000000, enables_d};
			default:
				readWord_d = 32'h00000000;
		endcase
	end

	// Read data loaded at the address phase so hrdata is a flop for the whole data phase
	always_ff @(posedge clock) begin
		if (!nrst) begin
			hrdata <= 32'h00000000;
		end else if (addrTake && !hwrite) begin
			hrdata <= readWord_d;
		end
	end

endmodule // cevs_regs

`default_nettype wire

// [cevs_pkg.sv]
// Package for the CAN event, status and receive-FIFO register group.
// Assumes a 32-bit AHB-Lite slave with one aligned word per register.
`default_nettype none

package cevs_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_VEC = 8'h00;
	localparam logic [7:0] OFF_CFG = 8'h04;
	localparam logic [7:0] OFF_PTR = 8'h08;
	localparam logic [7:0] OFF_FLG = 8'h0C;
	localparam logic [7:0] OFF_ENA = 8'h10;
	localparam logic [7:0] OFF_SIM = 8'h14;

	// Pending source codes
	localparam logic [6:0] CODE_NONE = 7'h40;
	localparam logic [6:0] CODE_ERR = 7'h41;
	localparam logic [6:0] CODE_WAKE = 7'h42;
	localparam logic [6:0] CODE_OVF = 7'h43;
	localparam logic [6:0] CODE_FIFO = 7'h44;
	localparam logic [6:0] CODE_INVALID = 7'h45;

	// Event flag positions
	localparam int BIT_TXBUF = 0;
	localparam int BIT_RXBUF = 1;
	localparam int BIT_OVF = 2;
	localparam int BIT_FIFO = 3;
	localparam int BIT_ERR = 5;
	localparam int BIT_WAKE = 6;
	localparam int BIT_INVALID = 7;
	localparam logic [7:0] FLAG_MASK = 8'hEF;

	// Field positions
	localparam int POS_HIT = 8;
	localparam int POS_SIZE = 13;
	localparam int POS_WRPTR = 8;
	localparam int POS_STATE = 8;

	// Reset values, reserved size code and last pointer
	localparam logic [2:0] RST_SIZE = 3'h0;
	localparam logic [4:0] RST_START = 5'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [3:0] RST_HIT = 4'h0;
	localparam logic [5:0] RST_PTR = 6'h00;
	localparam logic [2:0] SIZE_RESERVED = 3'h7;
	localparam logic [5:0] PTR_MAX = 6'h1F;

endpackage

`default_nettype wire

// [cevs_regs_properties.sv]
// Checker for the CAN event/status register group.
// Assumes it is bound to cevs_regs and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
// ********
// Checker
// ********
module cevs_regs_properties (
	// Clock and reset
	input wire logic clock,
	input wire logic nrst,
	// Bus side
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Controller side
	input wire logic [2:0] bufferRegionSize,
	input wire logic [4:0] fifoStartBuffer,
	input wire logic irqRequest
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// Read taken at this edge; data stands in the next cycle
	sequence s_rd(logic [7:0] a);
		hsel && hready && htrans[1] && !hwrite && haddr[7:0] == a;
	endsequence
	// Write taken, then its data phase
	sequence s_wr(logic [7:0] a);
		hsel && hready && htrans[1] && hwrite && haddr[7:0] == a ##1 1'b1;
	endsequence
	property p_cfgSize;
		s_wr(cevs_pkg::OFF_CFG) ##0 hwdata[15:13] != 3'h7
			|=> bufferRegionSize == $past(hwdata[15:13]);
	endproperty
	property p_cfgKeep;
		s_wr(cevs_pkg::OFF_CFG) ##0 hwdata[15:13] == 3'h7 |=> $stable(bufferRegionSize);
	endproperty
	property p_noRsv;
		bufferRegionSize != 3'h7;
	endproperty
	property p_start;
		s_wr(cevs_pkg::OFF_CFG) |=> fifoStartBuffer == $past(hwdata[4:0]);
	endproperty
	// Only filters 0..15 and the listed source codes may appear
	property p_vec;
		s_rd(cevs_pkg::OFF_VEC) |=> hrdata[31:12] == 20'h0 && !hrdata[7]
			&& (hrdata[6:0] <= 7'h0F || hrdata[6:0] inside {[7'h40:7'h44]});
	endproperty
	property p_ptr;
		s_rd(cevs_pkg::OFF_PTR) |=> hrdata[31:14] == 18'h0 && hrdata[7:6] == 2'h0
			&& !hrdata[13] && !hrdata[5];
	endproperty
	property p_flg;
		s_rd(cevs_pkg::OFF_FLG) |=> hrdata[31:14] == 18'h0 && !hrdata[4]
			&& hrdata[8] == (hrdata[10] | hrdata[9]);
	endproperty
	property p_ena;
		s_rd(cevs_pkg::OFF_ENA) |=> hrdata[31:8] == 24'h0 && !hrdata[4];
	endproperty
	// Enables cleared: the request must be gone once the enables have landed
	property p_mask;
		s_wr(cevs_pkg::OFF_ENA) ##0 hwdata[7:0] == 8'h00 |-> ##2 !irqRequest;
	endproperty
	a_cfgSize: assert property (p_cfgSize) else $error("size not loaded");
	a_cfgKeep: assert property (p_cfgKeep) else $error("reserved size taken");
	a_noRsv: assert property (p_noRsv) else $error("reserved size driven");
	a_start: assert property (p_start) else $error("start not loaded");
	a_vec: assert property (p_vec) else $error("bad vector read");
	a_ptr: assert property (p_ptr) else $error("bad pointer read");
	a_flg: assert property (p_flg) else $error("bad flag read");
	a_ena: assert property (p_ena) else $error("bad enable read");
	a_mask: assert property (p_mask) else $error("request while masked");
endmodule // cevs_regs_properties

bind cevs_regs cevs_regs_properties u_props (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hrdata, .bufferRegionSize, .fifoStartBuffer, .irqRequest);
`default_nettype wire

// [cevs_node_model.sv]
// Model of the controller and bus side feeding events and error states.
// Assumes the bench calls its tasks; outputs change just after a rising edge.
`timescale 1ns/1ns
`default_nettype none
// ********
// Node model
// ********
module cevs_node_model (
	// Clock
	input wire logic clock,
	// Events and states
	output logic evTxBuf,
	output logic evRxBuf,
	output logic evOverflow,
	output logic evFifoAlmostFull,
	output logic evInvalid,
	output logic busActivity,
	output logic [3:0] evBufNum,
	output logic [3:0] evFilterHit,
	// Mode and error-state levels
	output logic moduleDisabled,
	output logic txBusOff,
	output logic txPassive,
	output logic rxPassive,
	output logic txWarning,
	output logic rxWarning,
	// FIFO pointer steps
	output logic fifoWriteAdvance,
	output logic fifoReadAdvance
);
	logic [7:0] pulseQ = 8'h00;
	logic [5:0] stateQ = 6'h00;
	logic [3:0] numQ = 4'h0;
	logic [3:0] hitQ = 4'h0;
	// Pulses last one cycle so the design never counts one event twice
	assign {fifoReadAdvance, fifoWriteAdvance, busActivity, evInvalid} = pulseQ[7:4];
	assign {evFifoAlmostFull, evOverflow, evRxBuf, evTxBuf} = pulseQ[3:0];
	assign {moduleDisabled, txBusOff, txPassive, rxPassive, txWarning, rxWarning} = stateQ;
	assign evBufNum = numQ;
	assign evFilterHit = hitQ;
	task automatic pulse(input int k, input logic [3:0] n, input logic [3:0] h);
		@(posedge clock);
		numQ <= n;
		hitQ <= h;
		pulseQ <= 8'h01 << k;
		@(posedge clock);
		pulseQ <= 8'h00;
	endtask
	// Error states are levels held until changed
	task automatic setState(input logic [5:0] s);
		@(posedge clock);
		stateQ <= s;
	endtask
endmodule // cevs_node_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the CAN event/status register group.
// Assumes one zero-wait AHB-Lite slave and the node model on the controller side.
`timescale 1ns/1ns
`default_nettype none
// ********
// Bench
// ********
module tb_top;
	typedef struct {
		logic [7:0] a;
		logic w;
		logic [31:0] d;
		logic [7:0] ra;
		logic [31:0] e;
	} cevs_row_s;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	logic [31:0] stateExp;
	wire logic [31:0] hrdata;
	wire logic hready, hreadyout, hresp, irqRequest;
	wire logic [2:0] bufferRegionSize;
	wire logic [4:0] fifoStartBuffer;
	wire logic evTxBuf, evRxBuf, evOverflow, evFifoAlmostFull, evInvalid, busActivity;
	wire logic [3:0] evBufNum, evFilterHit;
	wire logic moduleDisabled, txBusOff, txPassive, rxPassive, txWarning, rxWarning;
	wire logic fifoWriteAdvance, fifoReadAdvance;
	int n_mismatch = 0;
	int compares = 0;
	int pk [4] = '{2, 3, 5, 4};
	int bt [4] = '{2, 3, 6, 7};
	logic [31:0] cd [4] = '{32'h43, 32'h44, 32'h42, 32'h40};
	// Write (optional), then read back and compare
	cevs_row_s rows [13] = '{'{8'h00,0,0,8'h00,32'h40}, '{8'h04,0,0,8'h04,0}, '{8'h08,0,0,8'h08,0},
		'{8'h0C,0,0,8'h0C,0}, '{8'h10,0,0,8'h10,0}, '{8'h10,1,32'hFFFFFFFF,8'h10,32'hEF},
		'{8'h00,1,32'hFFFFFFFF,8'h00,32'h40}, '{8'h08,1,32'hFFFFFFFF,8'h08,0},
		'{8'h0C,1,32'hFFFFFFFF,8'h0C,0}, '{8'h04,1,32'hFFFFFFFF,8'h04,32'h1F},
		'{8'h04,1,32'hC005,8'h08,32'h0505}, '{8'h04,0,0,8'h04,32'hC005},
		'{8'h20,1,32'hFFFFFFFF,8'h20,0}};
	assign hready = hreadyout;
	cevs_regs u_dut (.clock, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
		.hrdata, .hreadyout, .hresp, .evTxBuf, .evRxBuf, .evBufNum, .evFilterHit, .evOverflow,
		.evFifoAlmostFull, .evInvalid, .busActivity, .moduleDisabled, .txBusOff, .txPassive,
		.rxPassive, .txWarning, .rxWarning, .fifoWriteAdvance, .fifoReadAdvance,
		.bufferRegionSize, .fifoStartBuffer, .irqRequest);
	cevs_node_model u_node (.clock, .evTxBuf, .evRxBuf, .evOverflow, .evFifoAlmostFull,
		.evInvalid, .busActivity, .evBufNum, .evFilterHit, .moduleDisabled, .txBusOff,
		.txPassive, .rxPassive, .txWarning, .rxWarning, .fifoWriteAdvance, .fifoReadAdvance);
	initial forever #2 clock = ~clock;
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One single transfer; every phase is held until hready is seen high
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		ahb(a, 1'b0, 32'h0);
		chk(nm, rd, e);
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Watchdog: the whole sequence needs well under 10000 cycles
	initial begin
		#40000;
		n_mismatch++;
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) ahb(rows[i].a, 1'b1, rows[i].d);
			rdc("row", rows[i].ra, rows[i].e);
		end
		for (int s = 0; s < 7; s++) begin
			ahb(8'h04, 1'b1, 32'(s) << 13);
			rdc("cfg", 8'h04, 32'(s) << 13);
			chk("size", {29'h0, bufferRegionSize}, 32'(s));
		end
		// Pointer wrap from the last buffer back to the start buffer
		ahb(8'h04, 1'b1, 32'h1E);
		repeat (2) u_node.pulse(6, 4'h0, 4'h0);
		u_node.pulse(7, 4'h0, 4'h0);
		rdc("ptr", 8'h08, 32'h1E1F);
		chk("start", {27'h0, fifoStartBuffer}, 32'h1E);
		for (int i = 0; i < 5; i++) begin
			u_node.setState(6'h01 << i);
			stateExp = (32'h1 << (i + 9)) | (i < 2 ? 32'h120 : 32'h20);
			rdc("state", 8'h0C, stateExp);
			rdc("errcode", 8'h00, 32'h41);
			chk("irq", {31'h0, irqRequest}, 32'h1);
			u_node.setState(6'h00);
			ahb(8'h0C, 1'b1, 32'h0);
		end
		// Module disabled so bus activity raises the wake flag
		u_node.setState(6'h20);
		for (int k = 0; k < 4; k++) begin
			u_node.pulse(pk[k], 4'h0, 4'h0);
			rdc("flag", 8'h0C, 32'h1 << bt[k]);
			rdc("code", 8'h00, cd[k]);
			chk("irq", {31'h0, irqRequest}, 32'h1);
			ahb(8'h0C, 1'b1, 32'h0);
		end
		u_node.setState(6'h00);
		// Bus activity while enabled leaves the wake flag alone
		u_node.pulse(5, 4'h0, 4'h0);
		rdc("nowake", 8'h0C, 32'h0);
		u_node.pulse(1, 4'hF, 4'hF);
		rdc("rxbuf", 8'h00, 32'h0F0F);
		u_node.pulse(2, 4'h0, 4'h0);
		rdc("prio", 8'h00, 32'h0F43);
		ahb(8'h0C, 1'b1, 32'hFFFF);
		rdc("keep", 8'h0C, 32'h06);
		ahb(8'h0C, 1'b1, 32'h0);
		rdc("none", 8'h00, 32'h0F40);
		chk("irq", {31'h0, irqRequest}, 32'h0);
		u_node.pulse(0, 4'h7, 4'h3);
		rdc("txbuf", 8'h00, 32'h0307);
		ahb(8'h0C, 1'b1, 32'h0);
		ahb(8'h10, 1'b1, 32'h0);
		u_node.pulse(2, 4'h0, 4'h0);
		rdc("masked", 8'h0C, 32'h04);
		chk("irq", {31'h0, irqRequest}, 32'h0);
		// Second reset in mid-run with a flag pending
		@(posedge clock);
		nrst <= 1'b0;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		rdc("rstflg", 8'h0C, 32'h0);
		rdc("rstcfg", 8'h04, 32'h0);
		rdc("rstvec", 8'h00, 32'h40);
		chk("rstirq", {31'h0, irqRequest}, 32'h0);
		chk("bus", {30'h0, hreadyout, hresp}, 32'h2);
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
